// ### core/fiqt_pkg.sv
package fiqt_pkg;
   // Axis count and datapath widths
   localparam int NAX    = 4;
   localparam int AX_W   = 2;
   localparam int SEL_W  = 3;
   localparam int FB_W   = 16;
   localparam int DAC_W  = 16;
   localparam int ACC_W  = 32;
   localparam int POST_TRIGGER_DISTANCE_W = 23;
   localparam int DATA_W = 32;
   localparam int ADR_W  = 5;
   localparam int BE_W   = 4;

   // Timing: servo update period and event window
   localparam int CLK_PERIOD_NS    = 4;
   localparam int UPDATE_PERIOD_NS = 1000000;
   localparam int UPDATE_CYCLES    = (UPDATE_PERIOD_NS + CLK_PERIOD_NS - 1)
                                     / CLK_PERIOD_NS;
   localparam int DIV_W            = 32;
   localparam int EVT_CNT_W        = 4;
   localparam logic [EVT_CNT_W-1:0] EVT_HOLD_UPDATES = 4'h8;
   localparam logic [EVT_CNT_W-1:0] EVT_CNT_LAST     = 4'h1;

   // Travel limits in feedback counts
   localparam logic signed [ACC_W-1:0] WRONG_DIR_LIMIT = 32'sh0000_FFFF;

   // Register byte offsets
   localparam logic [ADR_W-1:0] OFS_HALT_REQ          = 5'h00;
   localparam logic [ADR_W-1:0] OFS_RESUME_ALLOW      = 5'h04;
   localparam logic [ADR_W-1:0] OFS_HALT_STATUS       = 5'h08;
   localparam logic [ADR_W-1:0] OFS_TRIG_SELECT       = 5'h0C;
   localparam logic [ADR_W-1:0] OFS_POST_TRIGGER_POST_TRIGGER_DISTANCE = 5'h10;
   localparam logic [ADR_W-1:0] OFS_TRIGGER_QUEUE_ARM = 5'h14;
   localparam logic [ADR_W-1:0] OFS_TRIG_STATUS       = 5'h18;
   localparam logic [ADR_W-1:0] OFS_PERR_CLEAR        = 5'h1C;
   localparam int WORD_LSB = 2;

   // Field positions
   localparam int HST_HALT_LSB   = 0;
   localparam int HST_RESUME_LSB = 8;
   localparam int SEL_FAST_LSB   = 0;
   localparam int SEL_MGD_LSB    = 4;
   localparam int TST_HOLD       = 0;
   localparam int TST_FIRED      = 1;
   localparam int TST_PERR_LSB   = 4;
   localparam logic [SEL_W-1:0] FAST_NONE = 3'h0;
   localparam logic [SEL_W-1:0] FAST_ONE  = 3'h1;

   // Trigger sequencer states, Gray along idle-wait-travel
   typedef enum logic [1:0] {
      FIQT_IDLE   = 2'h0,
      FIQT_WAIT   = 2'h1,
      FIQT_TRAVEL = 2'h3
   } fiqt_state_e;

   function automatic logic [NAX-1:0] fiqt_onehot(input logic [AX_W-1:0] a);
      fiqt_onehot = '0;
      fiqt_onehot[a] = 1'b1;
   endfunction

   function automatic logic [DATA_W-1:0] fiqt_be_mask(
      input logic [BE_W-1:0] be);
      for (int i = 0; i < BE_W; i++) begin
         fiqt_be_mask[i*8 +: 8] = {8{be[i]}};
      end
   endfunction
endpackage

// ### core/fiqt_tick_div.sv
`timescale 1ns/1ps
`default_nettype none
module fiqt_tick_div #(
   parameter int CYC = fiqt_pkg::UPDATE_CYCLES
) (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic arst_n,
   // Servo update enable
   output var  logic tick
);
   import fiqt_pkg::*;

   typedef struct packed {
      logic [DIV_W-1:0] cnt;
      logic             tick;
   } fiqt_div_s;

   fiqt_div_s s_r;
   fiqt_div_s s_nxt;

   localparam logic [DIV_W-1:0] CNT_TOP = DIV_W'(CYC - 1);

   always_comb begin
      s_nxt = s_r;
      s_nxt.tick = 1'b0;
      if (s_r.cnt == CNT_TOP) begin
         s_nxt.cnt  = '0;
         s_nxt.tick = 1'b1;
      end else begin
         s_nxt.cnt = s_r.cnt + DIV_W'(1);
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign tick = s_r.tick;
endmodule
`default_nettype wire

// ### core/fiqt_evt_stretch.sv
`timescale 1ns/1ps
`default_nettype none
module fiqt_evt_stretch (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic arst_n,
   // Update enable and fast input
   input  wire logic tick,
   input  wire logic fast_in,
   // Stretched event bit
   output var  logic evt
);
   import fiqt_pkg::*;

   typedef struct packed {
      logic                 prev;
      logic                 ev;
      logic [EVT_CNT_W-1:0] cnt;
   } fiqt_evt_s;

   fiqt_evt_s s_r;
   fiqt_evt_s s_nxt;

   always_comb begin
      s_nxt = s_r;
      s_nxt.prev = fast_in;
      if (fast_in && !s_r.prev) begin
         s_nxt.ev  = 1'b1;
         s_nxt.cnt = EVT_HOLD_UPDATES;
      end else if (s_r.ev && tick) begin
         s_nxt.cnt = s_r.cnt - EVT_CNT_LAST;
         if (s_r.cnt == EVT_CNT_LAST) begin
            s_nxt.ev = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign evt = s_r.ev;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   a_evt_holds: assert property (
      (s_r.ev && !tick && !(fast_in && !s_r.prev)) |=> s_r.ev)
      else $error("event bit dropped between updates");
   a_evt_count: assert property (
      (fast_in && !s_r.prev) |=> (s_r.ev && s_r.cnt == EVT_HOLD_UPDATES))
      else $error("event window not loaded with eight updates");
endmodule
`default_nettype wire

// ### core/fiqt_core.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Halt opens loop and zeroes command
// - Halt enters resume mode when allowed
// - Halt query returns active halt flag
// - Hold until fast input plus distance
// - Wrong-direction travel raises program error
// - Program error sticky until explicit clear
// - Event bit lasts eight updates
// - Fast input before arming is ignored
// - Start mode starts held move
// - Transition mode aborts, starts next move
// - Early completion lets next move run
// - End mode terminates move on release
// - No fast input: move ends normally
// - Arming with axis zero cancels hold
// - Managed axis selected independently
module fiqt_core #(
   parameter int UPDATE_CYC = fiqt_pkg::UPDATE_CYCLES
) (
   // Clock and reset
   input  wire logic                                      clk_sys,
   input  wire logic                                      arst_n,
   // Avalon-MM slave
   input  wire logic [fiqt_pkg::ADR_W-1:0]                avs_address,
   input  wire logic                                      avs_read,
   input  wire logic                                      avs_write,
   input  wire logic [fiqt_pkg::DATA_W-1:0]               avs_writedata,
   input  wire logic [fiqt_pkg::BE_W-1:0]                 avs_byteenable,
   output var  logic [fiqt_pkg::DATA_W-1:0]               avs_readdata,
   output var  logic                                      avs_waitrequest,
   // Axis feedback
   input  wire logic [fiqt_pkg::NAX-1:0]                  fast_in,
   input  wire logic [fiqt_pkg::NAX-1:0][fiqt_pkg::FB_W-1:0] fb_delta,
   // Servo command path
   input  wire logic [fiqt_pkg::NAX-1:0][fiqt_pkg::DAC_W-1:0] dac_cmd,
   output var  logic [fiqt_pkg::NAX-1:0][fiqt_pkg::DAC_W-1:0] dac_out,
   output var  logic [fiqt_pkg::NAX-1:0]                  loop_closed,
   output var  logic [fiqt_pkg::NAX-1:0]                  halt_active_flag,
   output var  logic [fiqt_pkg::NAX-1:0]                  resume_mode,
   // Queue status from motion generators
   input  wire logic [fiqt_pkg::NAX-1:0]                  q_active_loaded,
   input  wire logic [fiqt_pkg::NAX-1:0]                  q_running,
   input  wire logic [fiqt_pkg::NAX-1:0]                  q_next_loaded,
   input  wire logic [fiqt_pkg::NAX-1:0]                  q_done,
   // Queue control to motion generators
   output var  logic [fiqt_pkg::NAX-1:0]                  q_hold,
   output var  logic [fiqt_pkg::NAX-1:0]                  q_start,
   output var  logic [fiqt_pkg::NAX-1:0]                  q_switch,
   output var  logic [fiqt_pkg::NAX-1:0]                  q_end,
   output var  logic [fiqt_pkg::NAX-1:0]                  prog_error
);
   import fiqt_pkg::*;

   typedef struct packed {
      logic [NAX-1:0]             halt;
      logic [NAX-1:0]             resume;
      logic [NAX-1:0]             resume_allow;
      logic [NAX-1:0]             perr;
      logic [NAX-1:0][DAC_W-1:0]  dac;
      logic [SEL_W-1:0]           fast_sel;
      logic [AX_W-1:0]            mgd_sel;
      logic [POST_TRIGGER_DISTANCE_W-1:0]          post_trigger_distance;
      fiqt_state_e                st;
      logic [AX_W-1:0]            fidx;
      logic [AX_W-1:0]            midx;
      logic [POST_TRIGGER_DISTANCE_W-1:0]          arm_post_trigger_distance;
      logic                       ran_at_arm;
      logic                       fired;
      logic [ACC_W-1:0]           acc;
      logic [NAX-1:0]             evt_prev;
      logic [NAX-1:0]             start;
      logic [NAX-1:0]             switch_mv;
      logic [NAX-1:0]             end_mv;
      logic                       ack;
      logic [DATA_W-1:0]          rdata;
   } fiqt_core_s;

   fiqt_core_s s_r;
   fiqt_core_s s_nxt;

   logic                     tick;
   logic [NAX-1:0]           evt;
   logic                     req;
   logic                     wr_take;
   logic [DATA_W-1:0]        wmask;
   logic [ADR_W-1:0]         wadr;
   logic                     wr_arm;
   logic                     holding;
   logic                     evt_rise;
   logic                     dir_pos;
   logic signed [ACC_W-1:0]  acc_s;
   logic signed [ACC_W-1:0]  post_trigger_distance_ext;
   logic signed [ACC_W-1:0]  delta_ext;
   logic                     reached;
   logic                     wrong_dir;
   logic                     done_cancel;

   fiqt_tick_div #(
      .CYC(UPDATE_CYC)
   ) u_div (
      .clk_sys(clk_sys),
      .arst_n (arst_n),
      .tick   (tick)
   );

   for (genvar g = 0; g < NAX; g++) begin : g_evt
      fiqt_evt_stretch u_evt (
         .clk_sys(clk_sys),
         .arst_n (arst_n),
         .tick   (tick),
         .fast_in(fast_in[g]),
         .evt    (evt[g])
      );
   end

   // Bus: one wait cycle, write acts on the edge after the wait ends
   assign req     = avs_read || avs_write;
   assign wr_take = avs_write && s_r.ack;
   assign wmask   = fiqt_be_mask(avs_byteenable);
   assign wadr    = {avs_address[ADR_W-1:WORD_LSB], {WORD_LSB{1'b0}}};
   assign wr_arm  = wr_take && (wadr == OFS_TRIGGER_QUEUE_ARM)
                    && avs_byteenable[0];

   // Sequencer helpers
   assign holding   = (s_r.st != FIQT_IDLE);
   assign evt_rise  = evt[s_r.fidx] && !s_r.evt_prev[s_r.fidx];
   assign dir_pos   = !s_r.arm_post_trigger_distance[POST_TRIGGER_DISTANCE_W-1];
   assign acc_s     = $signed(s_r.acc);
   assign post_trigger_distance_ext  = $signed({{(ACC_W-POST_TRIGGER_DISTANCE_W){s_r.arm_post_trigger_distance[POST_TRIGGER_DISTANCE_W-1]}},
                               s_r.arm_post_trigger_distance});
   assign delta_ext = $signed({{(ACC_W-FB_W){fb_delta[s_r.fidx][FB_W-1]}},
                               fb_delta[s_r.fidx]});
   assign reached   = dir_pos ? (acc_s >= post_trigger_distance_ext) : (acc_s <= post_trigger_distance_ext);
   assign wrong_dir = dir_pos ? (acc_s < -WRONG_DIR_LIMIT)
                              : (acc_s > WRONG_DIR_LIMIT);
   assign done_cancel = holding && s_r.ran_at_arm && q_done[s_r.midx];

   always_comb begin
      s_nxt = s_r;
      s_nxt.start     = '0;
      s_nxt.switch_mv = '0;
      s_nxt.end_mv    = '0;
      s_nxt.evt_prev  = evt;
      s_nxt.ack       = req && !s_r.ack;

      if (avs_read && !s_r.ack) begin
         s_nxt.rdata = '0;
         unique case (wadr)
            OFS_RESUME_ALLOW: begin
               s_nxt.rdata[NAX-1:0] = s_r.resume_allow;
            end
            OFS_HALT_STATUS: begin
               s_nxt.rdata[HST_HALT_LSB +: NAX]   = s_r.halt;
               s_nxt.rdata[HST_RESUME_LSB +: NAX] = s_r.resume;
            end
            OFS_TRIG_SELECT: begin
               s_nxt.rdata[SEL_FAST_LSB +: SEL_W] = s_r.fast_sel;
               s_nxt.rdata[SEL_MGD_LSB +: AX_W]   = s_r.mgd_sel;
            end
            OFS_POST_TRIGGER_POST_TRIGGER_DISTANCE: begin
               s_nxt.rdata = DATA_W'(post_trigger_distance_ext_of(s_r.post_trigger_distance));
            end
            OFS_TRIG_STATUS: begin
               s_nxt.rdata[TST_HOLD]             = holding;
               s_nxt.rdata[TST_FIRED]            = s_r.fired;
               s_nxt.rdata[TST_PERR_LSB +: NAX]  = s_r.perr;
            end
            default: begin
               s_nxt.rdata = '0;
            end
         endcase
      end

      if (wr_take) begin
         unique case (wadr)
            OFS_HALT_REQ: begin
               if (avs_byteenable[0]) begin
                  s_nxt.halt = s_r.halt
                               | fiqt_onehot(avs_writedata[AX_W-1:0]);
                  s_nxt.resume = s_r.resume
                                 | (fiqt_onehot(avs_writedata[AX_W-1:0])
                                    & s_r.resume_allow);
               end
            end
            OFS_RESUME_ALLOW: begin
               s_nxt.resume_allow = NAX'((DATA_W'(s_r.resume_allow) & ~wmask)
                                         | (avs_writedata & wmask));
            end
            OFS_TRIG_SELECT: begin
               if (avs_byteenable[0]) begin
                  s_nxt.fast_sel = avs_writedata[SEL_FAST_LSB +: SEL_W];
                  s_nxt.mgd_sel  = avs_writedata[SEL_MGD_LSB +: AX_W];
               end
            end
            OFS_POST_TRIGGER_POST_TRIGGER_DISTANCE: begin
               s_nxt.post_trigger_distance = POST_TRIGGER_DISTANCE_W'((DATA_W'(s_r.post_trigger_distance) & ~wmask)
                                    | (avs_writedata & wmask));
            end
            OFS_PERR_CLEAR: begin
               // Only explicit clear; set below wins
               if (avs_byteenable[0]) begin
                  s_nxt.perr = s_r.perr & ~avs_writedata[NAX-1:0];
               end
            end
            default: begin
            end
         endcase
      end

      // Halt zeroes the command at once
      for (int i = 0; i < NAX; i++) begin
         s_nxt.dac[i] = s_nxt.halt[i] ? '0 : dac_cmd[i];
      end

      if (wr_arm) begin
         if (s_r.fast_sel == FAST_NONE) begin
            s_nxt.st = FIQT_IDLE;
         end else begin
            s_nxt.st         = FIQT_WAIT;
            s_nxt.fidx       = AX_W'(s_r.fast_sel - FAST_ONE);
            s_nxt.midx       = s_r.mgd_sel;
            s_nxt.arm_post_trigger_distance   = s_r.post_trigger_distance;
            s_nxt.ran_at_arm = q_running[s_r.mgd_sel];
            s_nxt.fired      = 1'b0;
            s_nxt.acc        = '0;
         end
      end else if (done_cancel) begin
         s_nxt.st = FIQT_IDLE;
      end else begin
         unique case (s_r.st)
            FIQT_IDLE: begin
            end
            FIQT_WAIT: begin
               if (evt_rise) begin
                  s_nxt.st    = FIQT_TRAVEL;
                  s_nxt.fired = 1'b1;
                  s_nxt.acc   = '0;
               end else if (tick) begin
                  s_nxt.acc = ACC_W'(acc_s + delta_ext);
               end
            end
            FIQT_TRAVEL: begin
               if (reached) begin
                  s_nxt.st = FIQT_IDLE;
                  if (q_running[s_r.midx] && q_next_loaded[s_r.midx]) begin
                     s_nxt.switch_mv = fiqt_onehot(s_r.midx);
                  end else if (q_running[s_r.midx]) begin
                     s_nxt.end_mv = fiqt_onehot(s_r.midx);
                  end else if (q_active_loaded[s_r.midx]) begin
                     s_nxt.start = fiqt_onehot(s_r.midx);
                  end
               end else if (tick) begin
                  s_nxt.acc = ACC_W'(acc_s + delta_ext);
               end
            end
            default: begin
               s_nxt.st = FIQT_IDLE;
            end
         endcase
      end

      if (holding && wrong_dir && !wr_arm) begin
         s_nxt.perr = s_nxt.perr | fiqt_onehot(s_r.midx);
      end
   end

   function automatic logic [ACC_W-1:0] post_trigger_distance_ext_of(
      input logic [POST_TRIGGER_DISTANCE_W-1:0] d);
      post_trigger_distance_ext_of = {{(ACC_W-POST_TRIGGER_DISTANCE_W){d[POST_TRIGGER_DISTANCE_W-1]}}, d};
   endfunction

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign avs_readdata     = s_r.rdata;
   assign avs_waitrequest  = req && !s_r.ack;
   assign dac_out          = s_r.dac;
   assign loop_closed      = ~s_r.halt;
   assign halt_active_flag = s_r.halt;
   assign resume_mode      = s_r.resume;
   // Only an idle move is held; a running one may chain on naturally
   assign q_hold   = (holding && !s_r.ran_at_arm) ? fiqt_onehot(s_r.midx)
                                                  : '0;
   assign q_start    = s_r.start;
   assign q_switch   = s_r.switch_mv;
   assign q_end      = s_r.end_mv;
   assign prog_error = s_r.perr;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   for (genvar g = 0; g < NAX; g++) begin : g_chk
      a_halt_dac_zero: assert property (
         halt_active_flag[g] |-> (dac_out[g] == '0 && !loop_closed[g]))
         else $error("halted axis still drives command");
      a_perr_sticky: assert property (
         (prog_error[g] && !(wr_take && wadr == OFS_PERR_CLEAR
          && avs_byteenable[0] && avs_writedata[g])) |=> prog_error[g])
         else $error("program error cleared without command");
   end

   a_halt_resume: assert property (
      (wr_take && wadr == OFS_HALT_REQ && avs_byteenable[0]
       && s_r.resume_allow[avs_writedata[AX_W-1:0]])
      |=> resume_mode[$past(avs_writedata[AX_W-1:0])])
      else $error("allowed halt did not enter resume mode");
   a_halt_query: assert property (
      (avs_read && !avs_waitrequest && wadr == OFS_HALT_STATUS)
      |-> avs_readdata[HST_HALT_LSB +: NAX] == $past(s_r.halt))
      else $error("halt query differs from halt flags");
   a_hold_release: assert property (
      (s_r.st == FIQT_TRAVEL && reached && !wr_arm && !done_cancel)
      |=> s_r.st == FIQT_IDLE)
      else $error("hold not released after distance");
   a_no_early_fire: assert property (
      (s_r.st == FIQT_IDLE && !wr_arm) |=> s_r.st == FIQT_IDLE)
      else $error("sequencer left idle without arming");
   a_wait_needs_edge: assert property (
      (s_r.st == FIQT_WAIT && !evt_rise && !wr_arm && !done_cancel)
      |=> s_r.st == FIQT_WAIT)
      else $error("left wait without fast input");
   a_wrong_dir_err: assert property (
      (holding && wrong_dir && !wr_arm) |=> prog_error[$past(s_r.midx)])
      else $error("wrong-direction travel not flagged");
   a_start_held: assert property (
      (s_r.st == FIQT_TRAVEL && reached && !wr_arm && !done_cancel
       && !q_running[s_r.midx] && q_active_loaded[s_r.midx])
      |=> q_start == fiqt_onehot($past(s_r.midx)) ##1 q_start == '0)
      else $error("held move not started on release");
   a_switch_next: assert property (
      (s_r.st == FIQT_TRAVEL && reached && !wr_arm && !done_cancel
       && q_running[s_r.midx] && q_next_loaded[s_r.midx])
      |=> q_switch == fiqt_onehot($past(s_r.midx)) && q_end == '0)
      else $error("transition not issued on release");
   a_end_move: assert property (
      (s_r.st == FIQT_TRAVEL && reached && !wr_arm && !done_cancel
       && q_running[s_r.midx] && !q_next_loaded[s_r.midx])
      |=> q_end == fiqt_onehot($past(s_r.midx)) && q_switch == '0)
      else $error("end not issued on release");
   a_done_cancel: assert property (
      (done_cancel && !wr_arm) |=> (s_r.st == FIQT_IDLE && q_hold == '0))
      else $error("completed move left hold active");
   a_cancel_zero: assert property (
      (wr_arm && s_r.fast_sel == FAST_NONE) |=> (!holding && q_hold == '0))
      else $error("arming with axis zero did not cancel");

   c_start: cover property (s_r.st == FIQT_WAIT ##[1:1000] q_start != '0);
   c_switch: cover property (q_switch != '0);
   c_end: cover property (q_end != '0);
   c_perr: cover property ($rose(prog_error[0]));
endmodule
`default_nettype wire

// ### sim/fiqt_axis_model.sv
`timescale 1ns/1ps
`default_nettype none
module fiqt_axis_model
   import fiqt_pkg::*;
(
   // Clock and reset
   input  wire logic           clk_sys,
   input  wire logic           arst_n,
   // Program side
   input  wire logic [NAX-1:0] ld_act,
   input  wire logic [NAX-1:0] ld_next,
   input  wire logic [NAX-1:0] flush,
   input  wire logic [NAX-1:0] fin,
   // Queue control in
   input  wire logic [NAX-1:0] q_hold,
   input  wire logic [NAX-1:0] q_start,
   input  wire logic [NAX-1:0] q_switch,
   input  wire logic [NAX-1:0] q_end,
   // Queue status out
   output var  logic [NAX-1:0] q_active_loaded,
   output var  logic [NAX-1:0] q_running,
   output var  logic [NAX-1:0] q_next_loaded,
   output var  logic [NAX-1:0] q_done
);
   // Normal end only on the bench's finish strobe, never by itself
   assign q_done = fin & q_running;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         q_active_loaded <= '0;
         q_running       <= '0;
         q_next_loaded   <= '0;
      end else begin
         for (int i = 0; i < NAX; i++) begin
            if (flush[i]) begin
               q_active_loaded[i] <= 1'b0;
               q_running[i]       <= 1'b0;
               q_next_loaded[i]   <= 1'b0;
            end else begin
               if (ld_act[i]) q_active_loaded[i] <= 1'b1;
               if (ld_next[i]) q_next_loaded[i] <= 1'b1;
               // Idle move starts once hold drops
               if (q_start[i] | (q_active_loaded[i] & ~q_hold[i]))
                  q_running[i] <= 1'b1;
               if (q_switch[i]) q_next_loaded[i] <= 1'b0;
               if (q_end[i]) begin
                  q_running[i]       <= 1'b0;
                  q_active_loaded[i] <= 1'b0;
               end
               if (fin[i] && q_running[i] && q_next_loaded[i]) begin
                  // Next move takes over at normal end
                  q_next_loaded[i] <= 1'b0;
               end else if (fin[i] && q_running[i]) begin
                  // Move ends at its own endpoint
                  q_running[i]       <= 1'b0;
                  q_active_loaded[i] <= 1'b0;
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

// ### sim/fast_input_queue_trigger_test.sv
`timescale 1ns/1ps
`default_nettype none
module fast_input_queue_trigger_test;
   import fiqt_pkg::*;
   logic clk_sys = 0, arst_n = 0, avs_read = 0, avs_write = 0;
   logic [ADR_W-1:0] avs_address = '0;
   logic [DATA_W-1:0] avs_writedata = '0, avs_readdata, rd;
   logic avs_waitrequest;
   logic [NAX-1:0] fast_in = '0, ld_act = '0, ld_next = '0, flush = '0;
   logic [NAX-1:0] fin = '0;
   localparam int LD_ACT = 0, LD_NEXT = 1, FLUSH = 2, FIN = 3;
   logic [NAX-1:0][FB_W-1:0] fb_delta = '0, dac_out;
   logic [NAX-1:0][DAC_W-1:0] dac_cmd = {4{16'h1234}};
   logic [NAX-1:0] loop_closed, halt_active_flag, resume_mode, q_done;
   logic [NAX-1:0] q_active_loaded, q_running, q_next_loaded;
   logic [NAX-1:0] q_hold, q_start, q_switch, q_end, prog_error;
   int n_errors = 0, n_checks = 0, n_st = 0, n_sw = 0, n_en = 0;
   always #2 clk_sys = ~clk_sys;
   // One tick shared by all four axes
   fiqt_core #(.UPDATE_CYC(4)) u_fiqt_core (.clk_sys(clk_sys),
      .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .fast_in(fast_in),
      .fb_delta(fb_delta), .dac_cmd(dac_cmd), .dac_out(dac_out),
      .loop_closed(loop_closed), .halt_active_flag(halt_active_flag),
      .resume_mode(resume_mode), .q_active_loaded(q_active_loaded),
      .q_running(q_running), .q_next_loaded(q_next_loaded),
      .q_done(q_done), .q_hold(q_hold), .q_start(q_start),
      .q_switch(q_switch), .q_end(q_end), .prog_error(prog_error));
   fiqt_axis_model u_fiqt_axis_model (.clk_sys(clk_sys), .arst_n(arst_n),
      .ld_act(ld_act), .ld_next(ld_next), .flush(flush), .q_hold(q_hold),
      .q_start(q_start), .q_switch(q_switch), .q_end(q_end),
      .q_active_loaded(q_active_loaded), .q_running(q_running),
      .q_next_loaded(q_next_loaded), .q_done(q_done), .fin(fin));
   always @(posedge clk_sys) begin
      n_st += (q_start[1] === 1'b1);
      n_sw += (q_switch[1] === 1'b1);
      n_en += (q_end[1] === 1'b1);
   end
   task automatic final_report();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] s, e);
      n_checks++;
      if (s !== e) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic bus(input logic w, input logic [ADR_W-1:0] a,
                      input logic [31:0] d);
      @(posedge clk_sys);
      avs_address <= a;
      avs_write <= w;
      avs_read <= ~w;
      avs_writedata <= d;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // Fast inputs spaced well over nine updates
   task automatic fire();
      @(posedge clk_sys) fast_in[2] <= 1'b1;
      wt(8);
      fast_in[2] <= 1'b0;
      wt(60);
   endtask
   task automatic pulse(input int k);
      @(posedge clk_sys);
      ld_act[1] <= (k == LD_ACT);
      ld_next[1] <= (k == LD_NEXT);
      flush[1] <= (k == FLUSH);
      fin[1] <= (k == FIN);
      @(posedge clk_sys);
      ld_act[1] <= 1'b0;
      ld_next[1] <= 1'b0;
      flush[1] <= 1'b0;
      fin[1] <= 1'b0;
   endtask
   initial begin
      wt(20000);
      n_errors++;
      final_report();
   end
   initial begin
      wt(4);
      arst_n <= 1'b1;
      fb_delta[2] <= 16'h0001;
      bus(0, OFS_HALT_STATUS, 0); chk("halt_st", rd, 0);
      bus(1, OFS_POST_TRIGGER_POST_TRIGGER_DISTANCE, 32'h007F_FFFD);
      bus(0, OFS_POST_TRIGGER_POST_TRIGGER_DISTANCE, 0); chk("post_trigger_distance", rd, 32'hFFFF_FFFD);
      bus(1, OFS_POST_TRIGGER_POST_TRIGGER_DISTANCE, 32'h0000_0003);
      bus(1, OFS_TRIG_SELECT, 32'h0000_0013);
      // Event before arming, let its window lapse
      fire();
      bus(1, OFS_TRIGGER_QUEUE_ARM, 1);
      pulse(LD_ACT);
      wt(30);
      chk("held", q_hold[1], 1);
      bus(0, OFS_TRIG_STATUS, 0); chk("hold", rd[0], 1);
      fire();
      chk("start", n_st, 1);
      bus(0, OFS_TRIG_STATUS, 0); chk("hold_off", rd[1:0], 2);
      bus(1, OFS_TRIGGER_QUEUE_ARM, 1);
      pulse(LD_NEXT);
      wt(40);
      chk("early_sw", n_sw, 0);
      fire();
      chk("switch", n_sw, 1);
      bus(1, OFS_TRIGGER_QUEUE_ARM, 1);
      pulse(LD_NEXT);
      pulse(FIN);
      bus(0, OFS_TRIG_STATUS, 0); chk("r13_hold", rd[0], 0);
      chk("r13_next", {q_running[1], q_next_loaded[1]}, 2);
      chk("r13_sw", n_sw, 1);
      bus(1, OFS_TRIGGER_QUEUE_ARM, 1);
      pulse(FIN);
      bus(0, OFS_TRIG_STATUS, 0); chk("r15_hold", rd[0], 0);
      chk("r15_run", q_running[1], 0);
      chk("r15_end", n_en, 0);
      pulse(LD_ACT);
      // End mode keeps next queue empty
      bus(1, OFS_TRIGGER_QUEUE_ARM, 1);
      wt(40);
      fire();
      chk("end", n_en, 1);
      fb_delta[2] <= 16'h8001;
      bus(1, OFS_TRIGGER_QUEUE_ARM, 1);
      wt(30);
      bus(0, OFS_TRIG_STATUS, 0); chk("perr", rd[7:4], 2);
      chk("perr_out", prog_error, 4'h2);
      bus(1, OFS_TRIG_SELECT, 32'h0000_0010);
      bus(1, OFS_TRIGGER_QUEUE_ARM, 1);
      bus(0, OFS_TRIG_STATUS, 0); chk("sticky", rd[7:0], 32'h20);
      bus(1, OFS_PERR_CLEAR, 2);
      bus(0, OFS_TRIG_STATUS, 0); chk("cleared", rd[7:4], 0);
      fb_delta[2] <= 16'h0001;
      pulse(FLUSH);
      bus(1, OFS_TRIG_SELECT, 32'h0000_0013);
      bus(1, OFS_TRIGGER_QUEUE_ARM, 1);
      pulse(LD_ACT);
      wt(4);
      chk("queued", q_running[1], 0);
      bus(1, OFS_TRIG_SELECT, 32'h0000_0010);
      bus(1, OFS_TRIGGER_QUEUE_ARM, 1);
      wt(4);
      chk("cancel", {q_hold[1], q_running[1]}, 1);
      bus(1, OFS_RESUME_ALLOW, 2);
      bus(1, OFS_HALT_REQ, 1);
      bus(1, OFS_HALT_REQ, 3);
      bus(0, OFS_HALT_STATUS, 0); chk("halt_st", rd, 32'h20A);
      chk("dac", {dac_out[1], dac_out[0]}, 32'h0000_1234);
      chk("loop", loop_closed, 4'h5);
      chk("flags", {resume_mode, halt_active_flag}, 8'h2A);
      final_report();
   end
endmodule
`default_nettype wire
